// ===== hw/tpc_core.sv
// Timer counter core: clocking, prescaler, 16-bit counter, APB registers
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
// Behaviour
// - Up mode: flag set on wrap to zero
// - Center mode: flag set stepping down from modulo
// - Flag clears by status read then write zero
// - New wrap during clear sequence restarts it
// - Writing one ignored; reset clears flag
// - Interrupt when flag and enable set
// - Center select gives up/down, center channels
// - Select clear: up only, channels own modes
// - Two-bit field disables or selects source
// - External and fixed clocks synchronised first
// - Eight-way prescaler after source selection
// - Reset selects no source; 01 bus clock
// - Both value bytes written, then moved together
// - Channel control write resets byte buffer
// - Debug mode holds counting
// - Wait runs; stop freezes until clocks return
// - Up count zero to terminal, then zero
module tpc_core
  import tpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fixed_rate_clock,
  input wire logic ext_clock_in,
  input wire logic debug_active,
  input wire logic stop_mode,
  output logic wrap_irq,
  output logic center_aligned_pwm,
  output logic [1:0] channel_mode_select,
  output logic [15:0] main_counter,
  output logic [15:0] channel_value
);
  tpc_state_t st_ff;
  tpc_state_t nxt_st;
  logic acc;
  logic wr;
  logic rd;
  logic tick_src;
  logic tick;
  logic [15:0] term;
  logic fix_rise;
  logic ext_rise;
  logic [7:0] sc_rd;
  logic wrap_evt;
  logic [7:0] ps_mask;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign sc_rd = {st_ff.sc.wrap_flag, st_ff.sc.wrap_irq_enable,
                  st_ff.sc.center_align_select,
                  st_ff.sc.clock_source_select, st_ff.sc.prescale_select};
  // Bit 0 of each sync chain feeds only bit 1
  assign fix_rise = st_ff.fix_sync[1] && !st_ff.fix_sync[2];
  assign ext_rise = st_ff.ext_sync[1] && !st_ff.ext_sync[2];
  assign term = (st_ff.modulo_value == `TPC_MOD_RESET) ?
                `TPC_CNT_TOP : st_ff.modulo_value;
  assign ps_mask = 8'h01 << st_ff.sc.prescale_select;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.fix_sync = {st_ff.fix_sync[1:0], fixed_rate_clock};
    nxt_st.ext_sync = {st_ff.ext_sync[1:0], ext_clock_in};
    // External edge seen reliably only below a quarter bus rate
    case (tpc_src_t'(st_ff.sc.clock_source_select))
      TPC_SRC_OFF: tick_src = 1'b0;
      TPC_SRC_BUS: tick_src = 1'b1;
      TPC_SRC_FIXED: tick_src = fix_rise;
      TPC_SRC_EXT: tick_src = ext_rise;
      default: tick_src = 1'b0;
    endcase
    // Stop is modelled by gating the count source only; wait mode needs nothing
    if (debug_active || stop_mode)
    begin
      tick_src = 1'b0;
    end
    tick = 1'b0;
    if (tick_src)
    begin
      nxt_st.presc = st_ff.presc + 7'h01;
      if ((({1'b0, st_ff.presc} + 8'h01) & (ps_mask - 8'h01)) == 8'h00)
      begin
        tick = 1'b1;
        nxt_st.presc = 7'h00;
      end
    end
    wrap_evt = 1'b0;
    if (tick)
    begin
      if (st_ff.sc.center_align_select)
      begin
        if (!st_ff.count_down)
        begin
          if (st_ff.main_counter >= term)
          begin
            nxt_st.count_down = 1'b1;
            nxt_st.main_counter = st_ff.main_counter - 16'h0001;
            wrap_evt = 1'b1;
          end
          else
          begin
            nxt_st.main_counter = st_ff.main_counter + 16'h0001;
          end
        end
        else if (st_ff.main_counter == `TPC_CNT_ZERO)
        begin
          nxt_st.count_down = 1'b0;
          nxt_st.main_counter = st_ff.main_counter + 16'h0001;
        end
        else
        begin
          nxt_st.main_counter = st_ff.main_counter - 16'h0001;
        end
      end
      else
      begin
        nxt_st.count_down = 1'b0;
        if (st_ff.main_counter >= term)
        begin
          nxt_st.main_counter = `TPC_CNT_ZERO;
          wrap_evt = 1'b1;
        end
        else
        begin
          nxt_st.main_counter = st_ff.main_counter + 16'h0001;
        end
      end
    end
    nxt_st.pready = psel && !penable;
    nxt_st.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `TPC_OFF_SC: nxt_st.prdata = {24'h00_0000, sc_rd};
        `TPC_OFF_CNT: nxt_st.prdata = {16'h0000, st_ff.main_counter};
        `TPC_OFF_MOD: nxt_st.prdata = {16'h0000, st_ff.modulo_value};
        `TPC_OFF_CVH: nxt_st.prdata = {24'h00_0000, st_ff.chan_value[15:8]};
        `TPC_OFF_CVL: nxt_st.prdata = {24'h00_0000, st_ff.chan_value[7:0]};
        `TPC_OFF_CSC: nxt_st.prdata = {24'h00_0000, st_ff.chan_sc};
        `TPC_OFF_CV: nxt_st.prdata = {16'h0000, st_ff.chan_value};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end
    if (rd && pready && paddr == `TPC_OFF_SC && st_ff.sc.wrap_flag)
    begin
      nxt_st.clr_armed = 1'b1;
    end
    if (wr && pready)
    begin
      case (paddr)
        `TPC_OFF_SC:
        begin
          nxt_st.sc.wrap_irq_enable = pwdata[`TPC_BIT_WIE];
          nxt_st.sc.center_align_select = pwdata[`TPC_BIT_CAS];
          nxt_st.sc.clock_source_select = pwdata[4:3];
          nxt_st.sc.prescale_select = pwdata[2:0];
          // Writing one leaves the flag alone
          if (st_ff.clr_armed && !pwdata[`TPC_BIT_WRAP])
          begin
            nxt_st.sc.wrap_flag = 1'b0;
          end
          nxt_st.clr_armed = 1'b0;
        end
        `TPC_OFF_CNT:
        begin
          nxt_st.main_counter = `TPC_CNT_ZERO;
          nxt_st.presc = 7'h00;
          nxt_st.count_down = 1'b0;
        end
        `TPC_OFF_MOD: nxt_st.modulo_value = pwdata[15:0];
        `TPC_OFF_CVH:
        begin
          nxt_st.buf_high = pwdata[7:0];
          nxt_st.got_high = 1'b1;
        end
        `TPC_OFF_CVL:
        begin
          nxt_st.buf_low = pwdata[7:0];
          nxt_st.got_low = 1'b1;
        end
        `TPC_OFF_CSC:
        begin
          nxt_st.chan_sc = pwdata[7:0];
          nxt_st.got_high = 1'b0;
          nxt_st.got_low = 1'b0;
        end
        default: nxt_st.chan_sc = st_ff.chan_sc;
      endcase
    end
    if (nxt_st.got_high && nxt_st.got_low)
    begin
      nxt_st.chan_value = {nxt_st.buf_high, nxt_st.buf_low};
      nxt_st.got_high = 1'b0;
      nxt_st.got_low = 1'b0;
    end
    if (wrap_evt) // Set wins over clear
    begin
      nxt_st.sc.wrap_flag = 1'b1;
      nxt_st.clr_armed = 1'b0;
    end
    nxt_st.irq = nxt_st.sc.wrap_flag && nxt_st.sc.wrap_irq_enable;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = 1'b0;
  assign wrap_irq = st_ff.irq;
  assign center_aligned_pwm = st_ff.sc.center_align_select;
  assign channel_mode_select = st_ff.chan_sc[3:2];
  assign main_counter = st_ff.main_counter;
  assign channel_value = st_ff.chan_value;
endmodule // tpc_core
`default_nettype wire

// ===== hw/tpc_defs.svh
// Offsets, field positions, reset values and count limits of the timer core
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_OFF_SC 12'h000
`define TPC_OFF_CNT 12'h004
`define TPC_OFF_MOD 12'h008
`define TPC_OFF_CVH 12'h00C
`define TPC_OFF_CVL 12'h010
`define TPC_OFF_CSC 12'h014
`define TPC_OFF_CV 12'h018
`define TPC_OFF_MODE 12'h01C
`define TPC_BIT_WRAP 7
`define TPC_BIT_WIE 6
`define TPC_BIT_CAS 5
`define TPC_SC_RESET 8'h00
`define TPC_MOD_RESET 16'h0000
`define TPC_CNT_TOP 16'hFFFF
`define TPC_CNT_ZERO 16'h0000
`endif

// ===== hw/tpc_pkg.sv
// Types of the timer counter core
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_SRC_OFF,
    TPC_SRC_BUS,
    TPC_SRC_FIXED,
    TPC_SRC_EXT
  } tpc_src_t;
  typedef struct packed {
    logic wrap_flag;
    logic wrap_irq_enable;
    logic center_align_select;
    logic [1:0] clock_source_select;
    logic [2:0] prescale_select;
  } tpc_sc_t;
  typedef struct packed {
    tpc_sc_t sc;
    logic clr_armed;
    logic [15:0] main_counter;
    logic [15:0] modulo_value;
    logic count_down;
    logic [6:0] presc;
    logic [2:0] fix_sync;
    logic [2:0] ext_sync;
    logic [7:0] buf_high;
    logic [7:0] buf_low;
    logic got_high;
    logic got_low;
    logic [15:0] chan_value;
    logic [7:0] chan_sc;
    logic [31:0] prdata;
    logic pready;
    logic irq;
  } tpc_state_t;
endpackage

// ===== test/tpc_core_props.sv
// Concurrent checks on the timer core ports
`timescale 1ns/1ps
`default_nettype none
module tpc_core_props
  import tpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debug_active,
  input wire logic stop_mode,
  input wire logic wrap_irq,
  input wire logic center_aligned_pwm,
  input wire logic [15:0] main_counter
);
  logic cas_ff;
  logic ie_ff;
  wire logic wr_sc = psel && penable && pready && pwrite && paddr == 12'h000;
  // Shadow of control bits as software last wrote them
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cas_ff <= 1'b0;
      ie_ff <= 1'b0;
    end
    else if (wr_sc)
    begin
      cas_ff <= pwdata[5];
      ie_ff <= pwdata[6];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_no_error: assert property (pslverr == 1'b0)
    else $error("pslverr raised");
  a_debug_hold: assert property (
    debug_active && $past(debug_active) |-> $stable(main_counter))
    else $error("counter moved in debug");
  a_stop_hold: assert property (
    stop_mode && $past(stop_mode) |-> $stable(main_counter))
    else $error("counter moved in stop");
  a_cas_copy: assert property (wr_sc |-> ##2 center_aligned_pwm == cas_ff)
    else $error("center output not from select");
  a_irq_mask: assert property (wrap_irq |-> ie_ff || $past(ie_ff))
    else $error("interrupt while disabled");
  a_cnt_step: assert property (!$stable(main_counter) |->
    main_counter == $past(main_counter) + 16'h0001 ||
    main_counter == $past(main_counter) - 16'h0001 ||
    main_counter == 16'h0000)
    else $error("counter jumped");
endmodule // tpc_core_props
bind tpc_core tpc_core_props u_props (.clock, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .debug_active, .stop_mode,
  .wrap_irq, .center_aligned_pwm, .main_counter);
`default_nettype wire

// ===== test/tb_tpc_core.sv
// Self-checking bench of the timer core over APB
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
module tb_tpc_core
  import tpc_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fixed_rate_clock = 1'b0, ext_clock_in = 1'b0;
  logic debug_active = 1'b0, stop_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic pready, pslverr, wrap_irq, center_aligned_pwm;
  logic [1:0] channel_mode_select;
  logic [15:0] main_counter, channel_value;
  int err_total = 0, total_checks = 0, cyc = 0;
  tpc_core u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fixed_rate_clock, .ext_clock_in,
    .debug_active, .stop_mode, .wrap_irq, .center_aligned_pwm,
    .channel_mode_select, .main_counter, .channel_value);
  always #4 clock = ~clock;
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Slow sources: fixed clock period 8, external period 6 (under a quarter)
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) fixed_rate_clock <= ~fixed_rate_clock;
    if (cyc % 3 == 2) ext_clock_in <= ~ext_clock_in;
    if (cyc == 20000)
    begin
      err_total += 1;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, got);
    total_checks += 1;
    if (got !== ex)
    begin
      err_total += 1;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  // Idle edge first, so psel never gets two assignments in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Cycles between two counter steps after a control write
  task automatic meas(input logic [7:0] sc, input int ex);
    logic [15:0] v;
    int n;
    apb(1'b1, `TPC_OFF_SC, sc);
    repeat (2) @(main_counter);
    v = main_counter;
    n = -1;
    while (main_counter === v)
    begin
      @(posedge clock);
      n += 1;
    end
    chk("tick spacing", ex, n);
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("sc reset", 8'h00, rd);
    tick(20);
    chk("cnt off", 16'h0000, main_counter);
    chk("irq reset", 1'b0, wrap_irq);
    for (int k = 0; k < 8; k++)
      meas(8'h08 | k[7:0], 1 << k);
    meas(8'h10, 8);
    meas(8'h19, 12);
    // Park the counter at zero so the first wrap comes from the modulo
    apb(1'b1, `TPC_OFF_SC, 8'h00);
    apb(1'b1, `TPC_OFF_CNT, 8'h00);
    apb(1'b1, `TPC_OFF_MOD, 8'h03);
    apb(1'b0, `TPC_OFF_CNT, 8'h00);
    chk("cnt cleared", 16'h0000, rd);
    apb(1'b0, `TPC_OFF_MOD, 8'h00);
    chk("mod read", 16'h0003, rd);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("flag idle", 8'h00, rd);
    apb(1'b1, `TPC_OFF_SC, 8'h48);
    wait (main_counter === 16'h0003);
    @(main_counter);
    chk("wrap to zero", 16'h0000, main_counter);
    tick(2);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("flag set", 8'hC8, rd);
    chk("irq on", 1'b1, wrap_irq);
    tick(8);
    debug_active <= 1'b1;
    apb(1'b1, `TPC_OFF_SC, 8'h48);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("rearm", 8'hC8, rd);
    apb(1'b1, `TPC_OFF_SC, 8'hC8);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("write one", 8'hC8, rd);
    apb(1'b1, `TPC_OFF_SC, 8'h48);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("cleared", 8'h48, rd);
    chk("irq off", 1'b0, wrap_irq);
    debug_active <= 1'b0;
    tick(8);
    stop_mode <= 1'b1;
    tick(6);
    stop_mode <= 1'b0;
    apb(1'b1, `TPC_OFF_SC, 8'h48);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("no read first", 8'hC8, rd);
    apb(1'b1, `TPC_OFF_SC, 8'h88);
    tick(2);
    chk("irq masked", 1'b0, wrap_irq);
    apb(1'b1, `TPC_OFF_MOD, 8'h04);
    // Frozen counter, so no wrap can cancel the armed clear sequence
    debug_active <= 1'b1;
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    apb(1'b1, `TPC_OFF_SC, 8'h28);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("flag clear", 8'h28, rd);
    debug_active <= 1'b0;
    tick(2);
    chk("center on", 1'b1, center_aligned_pwm);
    wait (main_counter === 16'h0004);
    @(main_counter);
    chk("count down", 16'h0003, main_counter);
    tick(2);
    apb(1'b0, `TPC_OFF_SC, 8'h00);
    chk("center flag", 8'hA8, rd);
    apb(1'b1, `TPC_OFF_SC, 8'h08);
    tick(2);
    chk("center off", 1'b0, center_aligned_pwm);
    apb(1'b1, `TPC_OFF_CVL, 8'h34);
    tick(2);
    chk("half pair", 16'h0000, channel_value);
    apb(1'b1, `TPC_OFF_CVH, 8'h12);
    tick(2);
    chk("pair", 16'h1234, channel_value);
    apb(1'b1, `TPC_OFF_CVL, 8'h56);
    apb(1'b1, `TPC_OFF_CSC, 8'h08);
    apb(1'b1, `TPC_OFF_CVH, 8'h78);
    tick(2);
    chk("buffer reset", 16'h1234, channel_value);
    chk("chan mode", 2'h2, channel_mode_select);
    apb(1'b1, `TPC_OFF_CVL, 8'h9A);
    tick(2);
    chk("pair again", 16'h789A, channel_value);
    apb(1'b0, `TPC_OFF_CV, 8'h00);
    chk("value read", 16'h789A, rd);
    apb(1'b0, `TPC_OFF_CVH, 8'h00);
    chk("high read", 8'h78, rd);
    apb(1'b0, `TPC_OFF_CVL, 8'h00);
    chk("low read", 8'h9A, rd);
    apb(1'b0, `TPC_OFF_CSC, 8'h00);
    chk("chan ctl read", 8'h08, rd);
    apb(1'b0, 12'h100, 8'h00);
    chk("unmapped", 8'h00, rd);
    wrap_up();
  end
endmodule // tb_tpc_core
`default_nettype wire
